/* File: hw/rhc_defines.vh */
// Constants of the timekeeping core with live hundredths read
`ifndef RHC_DEFINES_VH
`define RHC_DEFINES_VH

// --------------------------------------------------------------------
// Timing
// --------------------------------------------------------------------
`define RHC_CLK_PERIOD_NS   20
`define RHC_HUND_PERIOD_NS  10000000
`define RHC_TIMEOUT_NS      950000000

// --------------------------------------------------------------------
// Register offsets
// --------------------------------------------------------------------
`define RHC_ADDR_SEC        4'h0
`define RHC_ADDR_MIN        4'h1
`define RHC_ADDR_HOUR       4'h2
`define RHC_ADDR_HUND       4'h7
`define RHC_ADDR_CTRL       4'hd
`define RHC_ADDR_FLAG       4'he
`define RHC_ADDR_LAST       4'hf

// --------------------------------------------------------------------
// Field positions and reset values
// --------------------------------------------------------------------
`define RHC_BIT_UPDATE_EVENT_SELECT        5
`define RHC_BIT_UFLAG       5
`define RHC_RST_UPDATE_EVENT_SELECT        1'b0
`define RHC_RST_UFLAG       1'b0
`define RHC_RST_PTR         4'h0
`define RHC_READ_INVALID    8'hff

// --------------------------------------------------------------------
// Counter moduli (last value of each count)
// --------------------------------------------------------------------
`define RHC_HUND_LAST       8'h63
`define RHC_SEC_LAST        8'h3b
`define RHC_MIN_LAST        8'h3b
`define RHC_HOUR_LAST       8'h17

`endif

/* File: hw/rhc_wrap_counter.v */
// Wrapping binary counter used for each time digit group
`timescale 1ns/10ps
`include "rhc_defines.vh"

module rhc_wrap_counter #(
   parameter [7:0] LAST = 8'h3b
) (
   input  wire       clk,
   input  wire       reset_n,
   input  wire       inc,
   output wire [7:0] value,
   output wire       carry
);

   reg [7:0] count_r;
   reg [7:0] count_nxt;

   assign value = count_r;
   assign carry = inc && (count_r == LAST);

   always @* begin
      count_nxt = count_r;
      if (inc) begin
         if (count_r == LAST) begin
            count_nxt = 8'h00;
         end else begin
            count_nxt = count_r + 8'h01;
         end
      end
   end

   always @(posedge clk) begin
      if (!reset_n) begin
         count_r <= 8'h00;
      end else begin
         count_r <= count_nxt;
      end
   end

endmodule // rhc_wrap_counter

/* File: hw/rhc_core.v */
// Timekeeping core with access hold, live hundredths read and bus timeout
`timescale 1ns/10ps
`include "rhc_defines.vh"

module rhc_core #(
   parameter [31:0] HUND_CYCLES    = `RHC_HUND_PERIOD_NS / `RHC_CLK_PERIOD_NS,
   parameter [31:0] TIMEOUT_CYCLES = `RHC_TIMEOUT_NS / `RHC_CLK_PERIOD_NS
) (
   input  wire       clk,
   input  wire       reset_n,
   input  wire       busStart,
   input  wire       busStop,
   input  wire       addrLoad,
   input  wire [3:0] addrValue,
   input  wire       readStrobe,
   input  wire       writeStrobe,
   input  wire [7:0] writeData,
   output wire [7:0] readData,
   output wire       readValid,
   output wire       secondUpdateFlag,
   output wire       updateEventSelect,
   output wire       accessHold,
   output wire       busStandby,
   output wire [3:0] regPointer
);

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   reg  [31:0] divCount_r;
   reg  [31:0] toutCount_r;
   reg         hold_r;
   reg         timedOut_r;
   reg  [3:0]  ptr_r;
   reg  [3:0]  ptr_nxt;
   reg  [7:0]  readData_r;
   reg         readValid_r;
   reg  [7:0]  visSec_r;
   reg  [7:0]  visMin_r;
   reg  [7:0]  visHour_r;
   reg         uflag_r;
   reg         update_event_select_r;
   wire        hundTick;
   wire        secTick;
   wire        minTick;
   wire        hourTick;
   wire [7:0]  hundVal;
   wire [7:0]  secVal;
   wire [7:0]  minVal;
   wire [7:0]  hourVal;
   wire        busOk;
   wire        wrByte;
   wire        rdByte;

   assign readData          = readData_r;
   assign readValid         = readValid_r;
   assign secondUpdateFlag  = uflag_r;
   assign updateEventSelect = update_event_select_r;
   assign accessHold        = hold_r;
   assign busStandby        = timedOut_r;
   assign regPointer        = ptr_r;

   // Writes and address loads are ignored once the timeout has parked the interface; reads return all ones
   assign busOk  = !timedOut_r || busStart;
   assign wrByte = writeStrobe && busOk;
   assign rdByte = readStrobe;

   // -----------------------------------------------------------------
   // Wrap-around pointer step
   // -----------------------------------------------------------------
   function [3:0] nextAddr;
      input [3:0] a;
      begin
         if (a == `RHC_ADDR_LAST) begin
            nextAddr = 4'h0;
         end else begin
            nextAddr = a + 4'h1;
         end
      end
   endfunction

   // -----------------------------------------------------------------
   // Hundredths timebase
   // -----------------------------------------------------------------
   // Free running from reset; nothing in the bus path may stall it
   assign hundTick = (divCount_r == HUND_CYCLES - 32'h1);

   always @(posedge clk) begin
      if (!reset_n) begin
         divCount_r <= 32'h0;
      end else if (hundTick) begin
         divCount_r <= 32'h0;
      end else begin
         divCount_r <= divCount_r + 32'h1;
      end
   end

   // -----------------------------------------------------------------
   // Internal time counters (never held)
   // -----------------------------------------------------------------
   rhc_wrap_counter #(.LAST(`RHC_HUND_LAST)) uHund (
      .clk     (clk),
      .reset_n (reset_n),
      .inc     (hundTick),
      .value   (hundVal),
      .carry   (secTick)
   );

   rhc_wrap_counter #(.LAST(`RHC_SEC_LAST)) uSec (
      .clk     (clk),
      .reset_n (reset_n),
      .inc     (secTick),
      .value   (secVal),
      .carry   (minTick)
   );

   rhc_wrap_counter #(.LAST(`RHC_MIN_LAST)) uMin (
      .clk     (clk),
      .reset_n (reset_n),
      .inc     (minTick),
      .value   (minVal),
      .carry   (hourTick)
   );

   rhc_wrap_counter #(.LAST(`RHC_HOUR_LAST)) uHour (
      .clk     (clk),
      .reset_n (reset_n),
      .inc     (hourTick),
      .value   (hourVal),
      .carry   ()
   );

   // -----------------------------------------------------------------
   // Access hold and bus timeout
   // -----------------------------------------------------------------
   always @(posedge clk) begin
      if (!reset_n) begin
         hold_r      <= 1'b0;
         timedOut_r  <= 1'b0;
         toutCount_r <= 32'h0;
      end else if (busStart) begin
         hold_r      <= 1'b1;
         timedOut_r  <= 1'b0;
         toutCount_r <= 32'h0;
      end else if (busStop) begin
         hold_r      <= 1'b0;
         toutCount_r <= 32'h0;
      end else if (hold_r) begin
         if (toutCount_r >= TIMEOUT_CYCLES - 32'h1) begin
            hold_r      <= 1'b0;
            timedOut_r  <= 1'b1;
            toutCount_r <= 32'h0;
         end else begin
            toutCount_r <= toutCount_r + 32'h1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Visible time copies
   // -----------------------------------------------------------------
   // Visible copies track the internal counters whenever no access is
   // open, so ticks absorbed during a hold show up as soon as it drops.
   always @(posedge clk) begin
      if (!reset_n) begin
         visSec_r  <= 8'h00;
         visMin_r  <= 8'h00;
         visHour_r <= 8'h00;
      end else if (!hold_r) begin
         visSec_r  <= secVal;
         visMin_r  <= minVal;
         visHour_r <= hourVal;
      end
   end

   // -----------------------------------------------------------------
   // Register pointer
   // -----------------------------------------------------------------
   always @* begin
      ptr_nxt = ptr_r;
      if (addrLoad && busOk) begin
         ptr_nxt = addrValue;
      end else if (wrByte || (rdByte && !timedOut_r)) begin
         ptr_nxt = nextAddr(ptr_r);
      end
   end

   always @(posedge clk) begin
      if (!reset_n) begin
         ptr_r <= `RHC_RST_PTR;
      end else begin
         ptr_r <= ptr_nxt;
      end
   end

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   // Hundredths are sampled live at the read; held seconds may then be
   // one behind, a known limitation the host resolves by re-reading.
   always @(posedge clk) begin
      if (!reset_n) begin
         readData_r  <= 8'h00;
         readValid_r <= 1'b0;
      end else begin
         readValid_r <= rdByte;
         if (rdByte) begin
            if (timedOut_r) begin
               readData_r <= `RHC_READ_INVALID;
            end else begin
               case (ptr_r)
                  `RHC_ADDR_SEC: begin
                     readData_r <= visSec_r;
                  end
                  `RHC_ADDR_MIN: begin
                     readData_r <= visMin_r;
                  end
                  `RHC_ADDR_HOUR: begin
                     readData_r <= visHour_r;
                  end
                  `RHC_ADDR_HUND: begin
                     readData_r <= hundVal;
                  end
                  `RHC_ADDR_CTRL: begin
                     readData_r <= {2'b00, update_event_select_r, 5'b00000};
                  end
                  `RHC_ADDR_FLAG: begin
                     readData_r <= {2'b00, uflag_r, 5'b00000};
                  end
                  default: begin
                     readData_r <= 8'h00;
                  end
               endcase
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // Control bit and update flag
   // -----------------------------------------------------------------
   always @(posedge clk) begin
      if (!reset_n) begin
         update_event_select_r  <= `RHC_RST_UPDATE_EVENT_SELECT;
         uflag_r <= `RHC_RST_UFLAG;
      end else begin
         if (wrByte && ptr_r == `RHC_ADDR_CTRL) begin
            update_event_select_r <= writeData[`RHC_BIT_UPDATE_EVENT_SELECT];
         end
         // A tick in the clearing cycle must not be lost: set wins
         if (secTick && !update_event_select_r) begin
            uflag_r <= 1'b1;
         end else if (wrByte && ptr_r == `RHC_ADDR_FLAG &&
                      !writeData[`RHC_BIT_UFLAG]) begin
            uflag_r <= 1'b0;
         end
      end
   end

endmodule // rhc_core

/* File: tb/rhc_core_asserts.sv */
// Port assertions for the timekeeping core
`timescale 1ns/10ps
module rhc_core_asserts #(
   parameter [31:0] HUND_CYCLES    = 4,
   parameter [31:0] TIMEOUT_CYCLES = 50
) (
   input wire       clk,
   input wire       reset_n,
   input wire       busStart,
   input wire       busStop,
   input wire       addrLoad,
   input wire [3:0] addrValue,
   input wire       readStrobe,
   input wire       writeStrobe,
   input wire [7:0] writeData,
   input wire [7:0] readData,
   input wire       readValid,
   input wire       secondUpdateFlag,
   input wire       updateEventSelect,
   input wire       accessHold,
   input wire       busStandby,
   input wire [3:0] regPointer
);
   // ----------------------------------------
   // Hold length counter
   // ----------------------------------------
   reg [31:0] holdCnt_r;
   always @(posedge clk) begin
      if (!reset_n || busStart || !accessHold)
         holdCnt_r <= 32'h0;
      else
         holdCnt_r <= holdCnt_r + 32'h1;
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   hold_rise_a: assert property (busStart |=> accessHold)
      else $error("hold missing");
   hold_fall_a: assert property (
      busStop && !busStart |=> !accessHold)
      else $error("hold stuck");
   read_answer_a: assert property (readStrobe |=> readValid)
      else $error("no read answer");
   ptr_step_a: assert property (
      (readStrobe || writeStrobe) && !addrLoad && !busStandby
      |=> regPointer == $past(regPointer) + 4'h1)
      else $error("pointer step wrong");
   ptr_load_a: assert property (
      addrLoad && !busStandby |=> regPointer == $past(addrValue))
      else $error("pointer load wrong");
   flag_keep_a: assert property (
      secondUpdateFlag && !(writeStrobe && regPointer == 4'he
      && !writeData[5]) |=> secondUpdateFlag)
      else $error("flag lost");
   standby_data_a: assert property (
      readStrobe && busStandby && !busStart |=> readData == 8'hff)
      else $error("standby read not ones");
   standby_keep_a: assert property (
      busStandby && !busStart |=> busStandby)
      else $error("standby left early");
   hold_limit_a: assert property (
      holdCnt_r <= TIMEOUT_CYCLES + 1)
      else $error("hold outlived timeout");
   timeout_drop_a: assert property (
      accessHold && !busStart && !busStop
      && holdCnt_r == TIMEOUT_CYCLES - 1 |=> !accessHold && busStandby)
      else $error("timeout not taken");
   select_src_a: assert property (
      $changed(updateEventSelect)
      |-> $past(writeStrobe) && $past(regPointer) == 4'hd)
      else $error("select changed without write");
endmodule // rhc_core_asserts
bind rhc_core rhc_core_asserts #(
   .HUND_CYCLES(HUND_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) chk (
   .clk(clk), .reset_n(reset_n), .busStart(busStart), .busStop(busStop),
   .addrLoad(addrLoad), .addrValue(addrValue), .readStrobe(readStrobe),
   .writeStrobe(writeStrobe), .writeData(writeData), .readData(readData),
   .readValid(readValid), .secondUpdateFlag(secondUpdateFlag),
   .updateEventSelect(updateEventSelect), .accessHold(accessHold),
   .busStandby(busStandby), .regPointer(regPointer)
);

/* File: tb/rhc_host_model.sv */
// Host controller model issuing bus events to the core
`timescale 1ns/10ps
module rhc_host_model (
   input  wire       clk,
   input  wire       opGo,
   input  wire [2:0] opKind,
   input  wire [7:0] opArg,
   output wire       busStart,
   output wire       busStop,
   output wire       addrLoad,
   output wire [3:0] addrValue,
   output wire       readStrobe,
   output wire       writeStrobe,
   output wire [7:0] writeData
);
   // ----------------------------------------
   // Frame tracking
   // ----------------------------------------
   // A real master only sends bytes inside a START ... STOP frame
   reg  txnOpen_r = 1'b0;
   wire live;
   assign live = opGo && (txnOpen_r || opKind == 3'h0);
   always @(posedge clk) begin
      if (busStart) begin
         txnOpen_r <= 1'b1;
      end else if (busStop) begin
         txnOpen_r <= 1'b0;
      end
   end
   // ----------------------------------------
   // Bus events
   // ----------------------------------------
   // Kind 0 start, 1 stop, 2 address, 3 read, 4 write
   assign busStart    = live && (opKind == 3'h0);
   assign busStop     = live && (opKind == 3'h1);
   assign addrLoad    = live && (opKind == 3'h2);
   assign readStrobe  = live && (opKind == 3'h3);
   assign writeStrobe = live && (opKind == 3'h4);
   assign addrValue   = opArg[3:0];
   assign writeData   = opArg;
endmodule // rhc_host_model

/* File: tb/rhc_core_bench.sv */
// Self-checking bench for the timekeeping core
`timescale 1ns/10ps
module rhc_core_bench;
   reg         clk, reset_n, done, opGo;
   reg  [2:0]  opKind;
   reg  [7:0]  opArg;
   wire        bS, bP, aL, rS, wS, rV, uF, uS, aH, bSb;
   wire [3:0]  aV, rP;
   wire [7:0]  wD, rD;
   integer     miscompares = 0, checksDone = 0, i, j;
   reg  [8:0]  expQ[$];
   reg  [31:0] seed = 32'h1e;
   reg  [7:0]  d, s0, h0;
   rhc_host_model host (.clk(clk), .opGo(opGo), .opKind(opKind),
      .opArg(opArg), .busStart(bS), .busStop(bP), .addrLoad(aL),
      .addrValue(aV), .readStrobe(rS), .writeStrobe(wS), .writeData(wD));
   // Short counts: one hundredth is 4 cycles, one second 400
   rhc_core #(.HUND_CYCLES(32'h4), .TIMEOUT_CYCLES(32'h32)) dut (.clk(clk),
      .reset_n(reset_n), .busStart(bS), .busStop(bP), .addrLoad(aL),
      .addrValue(aV), .readStrobe(rS), .writeStrobe(wS), .writeData(wD),
      .readData(rD), .readValid(rV), .secondUpdateFlag(uF),
      .updateEventSelect(uS), .accessHold(aH), .busStandby(bSb),
      .regPointer(rP));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   function [7:0] rnd;
      input dummy;
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed[7:0];
      end
   endfunction
   task chk(input [7:0] seen, input [7:0] exp);
      checksDone = checksDone + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Kind 0 start, 1 stop, 2 address, 3 read, 4 write; one cycle each
   task op(input [2:0] k, input [7:0] a);
      @(negedge clk);
      opKind = k;
      opArg = a;
      opGo = 1'b1;
      @(negedge clk);
      opGo = 1'b0;
      // Stale data after the strobe so a held value is never trusted
      opArg = ~a;
   endtask
   task rd(output [7:0] v);
      op(3'h3, rnd(0));
      v = rD;
   endtask
   task wrap_up;
      if (miscompares == 0 && checksDone > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ----------------------------------------
   // Read result watcher
   // ----------------------------------------
   always @(negedge clk) begin
      if (rV === 1'b1 && expQ.size() == 0)
         chk(rD, ~rD);
      else if (rV === 1'b1 && expQ[0][8])
         chk(rD, expQ.pop_front());
      else if (rV === 1'b1)
         void'(expQ.pop_front());
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      opGo = 1'b0;
      opKind = 3'h0;
      opArg = 8'h00;
      reset_n = 1'b0;
      done = 1'b0;
      repeat (6) @(negedge clk);
      reset_n = 1'b1;
      chk({rP, uF, uS, aH, bSb}, 8'h00);
      op(3'h0, 8'h00);
      op(3'h2, 8'h0d);
      op(3'h4, 8'h20);
      chk(uS, 1'b1);
      op(3'h4, rnd(0) & 8'hdf);
      op(3'h2, 8'h0d);
      expQ.push_back(9'h120);
      rd(d);
      op(3'h1, 8'h00);
      repeat (400 + rnd(0)) @(negedge clk);
      chk(uF, 1'b0);
      op(3'h0, 8'h00);
      op(3'h2, 8'h0d);
      op(3'h4, 8'h00);
      chk(uS, 1'b0);
      op(3'h1, 8'h00);
      for (i = 0; i < 420 && uF !== 1'b1; i = i + 1) @(negedge clk);
      op(3'h0, 8'h00);
      op(3'h2, 8'h0e);
      op(3'h4, rnd(0) | 8'h20);
      op(3'h1, 8'h00);
      chk(uF, 1'b1);
      // Retry until a seconds tick lands inside the held access
      for (i = 0; i < 20 && !done; i = i + 1) begin
         op(3'h0, 8'h00);
         op(3'h2, 8'h0e);
         op(3'h4, rnd(0) & 8'hdf);
         op(3'h2, 8'h00);
         expQ.push_back(9'h000);
         rd(s0);
         for (j = 0; j < 20 && uF !== 1'b1; j = j + 1) begin
            @(negedge clk);
         end
         if (uF === 1'b1) begin
            expQ.push_back({1'b1, s0});
            op(3'h2, 8'h00);
            rd(d);
            expQ.push_back(9'h000);
            op(3'h2, 8'h07);
            rd(h0);
            expQ.push_back({1'b1, (h0 == 8'h63) ? 8'h00 : h0 + 8'h01});
            op(3'h2, 8'h07);
            rd(d);
            op(3'h1, 8'h00);
            repeat (2) @(negedge clk);
            expQ.push_back({1'b1, (s0 == 8'h3b) ? 8'h00 : s0 + 8'h01});
            op(3'h0, 8'h00);
            op(3'h2, 8'h00);
            rd(d);
            done = 1'b1;
         end
         op(3'h1, 8'h00);
      end
      chk(done, 1'b1);
      op(3'h0, 8'h00);
      op(3'h2, 8'h0f);
      expQ.push_back(9'h100);
      rd(d);
      chk(rP, 4'h0);
      repeat (60) @(negedge clk);
      chk({aH, bSb}, 8'h01);
      expQ.push_back(9'h1ff);
      rd(d);
      op(3'h0, 8'h00);
      chk({aH, bSb}, 8'h02);
      op(3'h1, 8'h00);
      repeat (3) @(negedge clk);
      chk(expQ.size(), 8'h00);
      wrap_up;
   end
endmodule // rhc_core_bench
